//--- verilog/cei_exc_unit.v
// Overview of operation
// - break instruction raises unmaskable breakpoint exception, common vector, breakpoint code.
// - return address written only with exception level clear; branch address if delay slot.
// - branch-delay indicator, with exception level clear, set for delay-slot exceptions and cleared otherwise.
// - break instruction bits 25 to 6 are ignored by hardware.
// - undefined primary, register-format function or register-immediate selector raises reserved exception.
// - undefined coprocessor source or target selector raises reserved exception.
// - 64-bit ops in 32-bit user/supervisor mode are reserved; kernel always allowed.
// - reserved exception is unmaskable, common vector, reserved code, normal return address.
// - coprocessor instruction with its usable bit clear raises coprocessor-unusable.
// - system coprocessor instructions free in kernel; else need its usable bit.
// - floating-point instruction without floating-point unit raises coprocessor-unusable.
// - coprocessor-unusable records its code and the coprocessor number.
// - coprocessor-unusable in delay slot loads branch address and sets delay indicator.
// - floating-point request raises unmaskable floating-point exception with its code.
// - floating-point condition persists until its unit's status bit is cleared.
// - eight interrupt sources, two software, six hardware from active request inputs.
// - software pending bits 1 and 0 raise interrupts; writing 0 removes them.
// - each interrupt masked by its mask bit; all masked by global enable 0.
// - 32-bit vector 0x80000180, or 0xbfc00380 with boot vector bit set.
// - 64-bit vector 0xffffffff80000180, or 0xffffffffbfc00380 with boot bit.
// - timer on pending bit 7; cleared by compare write or writing bit 7 low.
`include "cei_exc_defs.vh"

module cei_exc_unit #(
    parameter         FPU_PRESENT = 1,
    parameter [63:0]  OPC_DEFINED = 64'hf7ffffff0fffffff,
    parameter [63:0]  FN_DEFINED  = 64'hdd5ffcffffdfb3dd,
    parameter [31:0]  RT_DEFINED  = 32'h000f5f0f,
    parameter [31:0]  RS_DEFINED  = 32'hffff0177,
    parameter [31:0]  BC_DEFINED  = 32'h0000000f,
    parameter [63:0]  OPC_WIDE    = 64'h909030800f000000,
    parameter [63:0]  FN_WIDE     = 64'hdd00f000f0d00000
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire        instrValid,
    input  wire [31:0] instrWord,
    input  wire [63:0] instrPc,
    input  wire        inDelaySlot,
    input  wire        fpExcReq,
    input  wire [5:0]  external_interrupt_request_n,
    input  wire        timerMatch,
    input  wire        compareWrite,
    input  wire [2:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    output reg         excTake,
    output reg  [4:0]  excCode,
    output reg  [63:0] excVector,
    output reg         intPending
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    reg        globalIntEn_r;
    reg        exception_level_bit_r;
    reg [1:0]  ksu_r;
    reg        ux_r;
    reg        sx_r;
    reg        kernel_extended_addressing_bit_r;
    reg [7:0]  interrupt_mask_field_r;
    reg        boot_exception_vector_bit_r;
    reg [3:0]  coprocessor_usable_bit_r;
    reg [1:0]  swPending_r;
    reg        timerPending_r;
    reg [4:0]  causeCode_r;
    reg [1:0]  copError_r;
    reg        branch_delay_indicator_r;
    reg [63:0] exception_return_address_r;
    reg [5:0]  extSync1_r;
    reg [5:0]  extSync2_r;

    // ----------------------------------------------------------
    // decode
    // ----------------------------------------------------------
    wire [5:0] opc = instrWord[31:26];
    wire [4:0] rsSel = instrWord[25:21];
    wire [4:0] rtSel = instrWord[20:16];
    wire [5:0] fn = instrWord[5:0];
    wire [1:0] cpNum = opc[1:0];
    wire isSpecial = (opc == `CEI_OPC_SPECIAL);
    wire isRegImm = (opc == `CEI_OPC_REG_IMM);
    wire isCopGroup = (opc[5:2] == 4'h4);
    wire isCopLdSt = (opc[5:4] == 2'h3) && (cpNum == 2'h1 || cpNum == 2'h2);
    wire isCopInstr = isCopGroup | isCopLdSt;
    wire kernel = (ksu_r == `CEI_KSU_KERNEL) | exception_level_bit_r;

    wire isBreak = isSpecial && (fn == `CEI_FN_BREAK);

    wire riBase = !OPC_DEFINED[opc]
                | (isSpecial & !FN_DEFINED[fn])
                | (isRegImm & !RT_DEFINED[rtSel]);

    wire riCop = isCopGroup & (!RS_DEFINED[rsSel]
               | (rsSel == `CEI_RS_BRANCH & !BC_DEFINED[rtSel]));

    wire isWide = OPC_WIDE[opc] | (isSpecial & FN_WIDE[fn]);
    wire wideOk = kernel
                | (ksu_r == `CEI_KSU_USER & ux_r)
                | (ksu_r == `CEI_KSU_SUPER & sx_r);
    wire riWide = isWide & !wideOk;
    wire reservedHit = riBase | riCop | riWide;

    wire cpOff = (cpNum == 2'h0) ? (!kernel & !coprocessor_usable_bit_r[0])
               : (!coprocessor_usable_bit_r[cpNum]
                 | (cpNum == 2'h1 && FPU_PRESENT == 0));
    wire cpUnusable = isCopInstr & cpOff;

    // ----------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------
    // two software, six hardware
    wire [5:0] hwLevel = ~extSync2_r;
    wire [7:0] interrupt_pending_bits = {hwLevel[5] | timerPending_r,
                                         hwLevel[4:0], swPending_r};
    wire intReq = (|(interrupt_pending_bits & interrupt_mask_field_r))
                & globalIntEn_r & !exception_level_bit_r;

    // ----------------------------------------------------------
    // prioritised selection
    // ----------------------------------------------------------
    reg       raise;
    reg [4:0] codeNxt;
    always @* begin
        raise = instrValid;
        codeNxt = `CEI_CODE_INT;
        if (intReq) begin
            codeNxt = `CEI_CODE_INT;
        end else if (cpUnusable) begin
            codeNxt = `CEI_CODE_CPU;
        end else if (reservedHit) begin
            codeNxt = `CEI_CODE_RSV;
        end else if (isBreak) begin
            codeNxt = `CEI_CODE_BRK;
        end else if (fpExcReq) begin
            codeNxt = `CEI_CODE_FLT;
        end else begin
            raise = 1'b0;
        end
    end

    wire [63:0] retAddr = inDelaySlot ? (instrPc - `CEI_SLOT_BYTES) : instrPc;

    wire [63:0] vectNxt = kernel_extended_addressing_bit_r
        ? (boot_exception_vector_bit_r ? `CEI_VEC64_BOOT : `CEI_VEC64_NORM)
        : (boot_exception_vector_bit_r ? `CEI_VEC32_BOOT : `CEI_VEC32_NORM);

    wire wrStatus = regWr && (regAddr == `CEI_REG_STATUS);
    wire wrCause = regWr && (regAddr == `CEI_REG_CAUSE);
    wire wrRetLo = regWr && (regAddr == `CEI_REG_RET_LO);
    wire wrRetHi = regWr && (regAddr == `CEI_REG_RET_HI);

    // ----------------------------------------------------------
    // synchroniser
    // ----------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            extSync1_r <= 6'h3f;
            extSync2_r <= 6'h3f;
        end else begin
            extSync1_r <= external_interrupt_request_n;
            extSync2_r <= extSync1_r;
        end
    end

    // ----------------------------------------------------------
    // status
    // ----------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            globalIntEn_r <= 1'b0;
            exception_level_bit_r <= 1'b1;
            ksu_r <= `CEI_KSU_KERNEL;
            ux_r <= 1'b0;
            sx_r <= 1'b0;
            kernel_extended_addressing_bit_r <= 1'b0;
            interrupt_mask_field_r <= 8'h00;
            boot_exception_vector_bit_r <= 1'b1;
            coprocessor_usable_bit_r <= 4'h0;
        end else begin
            if (wrStatus) begin
                globalIntEn_r <= regWrData[`CEI_ST_GLB_EN];
                exception_level_bit_r <= regWrData[`CEI_ST_EXC_LVL];
                ksu_r <= regWrData[`CEI_ST_KSU_HI:`CEI_ST_KSU_LO];
                ux_r <= regWrData[`CEI_ST_UX];
                sx_r <= regWrData[`CEI_ST_SX];
                kernel_extended_addressing_bit_r <= regWrData[`CEI_ST_KEXT];
                interrupt_mask_field_r <= regWrData[`CEI_ST_MASK_HI:`CEI_ST_MASK_LO];
                boot_exception_vector_bit_r <= regWrData[`CEI_ST_BOOT_VEC];
                coprocessor_usable_bit_r <= regWrData[`CEI_ST_CU_HI:`CEI_ST_CU_LO];
            end
            // exception entry wins over a write
            if (raise) begin
                exception_level_bit_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------
    // cause, return address
    // ----------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            swPending_r <= 2'h0;
            timerPending_r <= 1'b0;
            causeCode_r <= `CEI_CODE_INT;
            copError_r <= 2'h0;
            branch_delay_indicator_r <= 1'b0;
            exception_return_address_r <= 64'h0000000000000000;
        end else begin
            if (wrCause) begin
                swPending_r <= regWrData[`CEI_CA_PEND_LO+1:`CEI_CA_PEND_LO];
            end
            if (timerMatch) begin
                timerPending_r <= 1'b1;
            end else if (compareWrite || (wrCause && !regWrData[`CEI_CA_TIMER])) begin
                timerPending_r <= 1'b0;
            end
            if (wrRetLo) begin
                exception_return_address_r[31:0] <= regWrData;
            end
            if (wrRetHi) begin
                exception_return_address_r[63:32] <= regWrData;
            end
            if (raise) begin
                causeCode_r <= codeNxt;
                if (!intReq && cpUnusable) begin
                    copError_r <= cpNum;
                end
                if (!exception_level_bit_r) begin
                    exception_return_address_r <= retAddr;
                    branch_delay_indicator_r <= inDelaySlot;
                end
            end
        end
    end

    // ----------------------------------------------------------
    // outputs and read port
    // ----------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            excTake <= 1'b0;
            excCode <= `CEI_CODE_INT;
            excVector <= `CEI_VEC32_BOOT;
            intPending <= 1'b0;
            regRdData <= 32'h00000000;
        end else begin
            excTake <= raise;
            if (raise) begin
                excCode <= codeNxt;
                excVector <= vectNxt;
            end
            intPending <= intReq;
            regRdData <= 32'h00000000;
            if (regRd) begin
                case (regAddr)
                    `CEI_REG_STATUS: begin
                        regRdData[`CEI_ST_GLB_EN] <= globalIntEn_r;
                        regRdData[`CEI_ST_EXC_LVL] <= exception_level_bit_r;
                        regRdData[`CEI_ST_KSU_HI:`CEI_ST_KSU_LO] <= ksu_r;
                        regRdData[`CEI_ST_UX] <= ux_r;
                        regRdData[`CEI_ST_SX] <= sx_r;
                        regRdData[`CEI_ST_KEXT] <= kernel_extended_addressing_bit_r;
                        regRdData[`CEI_ST_MASK_HI:`CEI_ST_MASK_LO] <= interrupt_mask_field_r;
                        regRdData[`CEI_ST_BOOT_VEC] <= boot_exception_vector_bit_r;
                        regRdData[`CEI_ST_CU_HI:`CEI_ST_CU_LO] <= coprocessor_usable_bit_r;
                    end
                    `CEI_REG_CAUSE: begin
                        regRdData[`CEI_CA_CODE_HI:`CEI_CA_CODE_LO] <= causeCode_r;
                        regRdData[`CEI_CA_PEND_HI:`CEI_CA_PEND_LO] <= interrupt_pending_bits;
                        regRdData[`CEI_CA_CE_HI:`CEI_CA_CE_LO] <= copError_r;
                        regRdData[`CEI_CA_DLY_SLOT] <= branch_delay_indicator_r;
                    end
                    `CEI_REG_RET_LO: begin
                        regRdData <= exception_return_address_r[31:0];
                    end
                    `CEI_REG_RET_HI: begin
                        regRdData <= exception_return_address_r[63:32];
                    end
                    `CEI_REG_VECT_LO: begin
                        regRdData <= vectNxt[31:0];
                    end
                    `CEI_REG_VECT_HI: begin
                        regRdData <= vectNxt[63:32];
                    end
                    default: begin
                        regRdData <= 32'h00000000;
                    end
                endcase
            end
        end
    end

endmodule

//--- verilog/cei_exc_defs.vh
`ifndef CEI_EXC_DEFS_VH
`define CEI_EXC_DEFS_VH

// --------------------------------------------------------------
// register word indices
// --------------------------------------------------------------
`define CEI_REG_STATUS   3'h0
`define CEI_REG_CAUSE    3'h1
`define CEI_REG_RET_LO   3'h2
`define CEI_REG_RET_HI   3'h3
`define CEI_REG_VECT_LO  3'h4
`define CEI_REG_VECT_HI  3'h5

// --------------------------------------------------------------
// status field positions
// --------------------------------------------------------------
`define CEI_ST_GLB_EN    0
`define CEI_ST_EXC_LVL   1
`define CEI_ST_KSU_LO    3
`define CEI_ST_KSU_HI    4
`define CEI_ST_UX        5
`define CEI_ST_SX        6
`define CEI_ST_KEXT      7
`define CEI_ST_MASK_LO   8
`define CEI_ST_MASK_HI   15
`define CEI_ST_BOOT_VEC  22
`define CEI_ST_CU_LO     28
`define CEI_ST_CU_HI     31

// --------------------------------------------------------------
// cause field positions
// --------------------------------------------------------------
`define CEI_CA_CODE_LO   2
`define CEI_CA_CODE_HI   6
`define CEI_CA_PEND_LO   8
`define CEI_CA_PEND_HI   15
`define CEI_CA_TIMER     15
`define CEI_CA_CE_LO     28
`define CEI_CA_CE_HI     29
`define CEI_CA_DLY_SLOT  31

// --------------------------------------------------------------
// reset values and mode codes
// --------------------------------------------------------------
`define CEI_RST_STATUS   32'h00400002
`define CEI_KSU_KERNEL   2'h0
`define CEI_KSU_SUPER    2'h1
`define CEI_KSU_USER     2'h2

// --------------------------------------------------------------
// cause codes
// --------------------------------------------------------------
`define CEI_CODE_INT     5'h00
`define CEI_CODE_BRK     5'h09
`define CEI_CODE_RSV     5'h0a
`define CEI_CODE_CPU     5'h0b
`define CEI_CODE_FLT     5'h0f

// --------------------------------------------------------------
// opcodes and vectors
// --------------------------------------------------------------
`define CEI_OPC_SPECIAL  6'h00
`define CEI_OPC_REG_IMM  6'h01
`define CEI_FN_BREAK     6'h0d
`define CEI_RS_BRANCH    5'h08
`define CEI_VEC32_NORM   64'h0000000080000180
`define CEI_VEC32_BOOT   64'h00000000bfc00380
`define CEI_VEC64_NORM   64'hffffffff80000180
`define CEI_VEC64_BOOT   64'hffffffffbfc00380
`define CEI_SLOT_BYTES   64'h0000000000000004

`endif

//--- tb/cei_exc_unit_properties.sv
module cei_exc_unit_properties (
    input logic        clk_sys,
    input logic        arst_n,
    input logic        instrValid,
    input logic [31:0] instrWord,
    input logic [63:0] instrPc,
    input logic        inDelaySlot,
    input logic        fpExcReq,
    input logic [5:0]  external_interrupt_request_n,
    input logic        timerMatch,
    input logic        compareWrite,
    input logic [2:0]  regAddr,
    input logic [31:0] regWrData,
    input logic        regWr,
    input logic        regRd,
    input logic [31:0] regRdData,
    input logic        excTake,
    input logic [4:0]  excCode,
    input logic [63:0] excVector,
    input logic        intPending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire isBrk = instrWord[31:26] == 6'h00 && instrWord[5:0] == 6'h0d;

    // ----------------------------------------
    // exception entry
    // ----------------------------------------
    a_brk_taken: assert property (instrValid && isBrk |=> excTake && excCode inside {5'h00, 5'h09})
        else $error("break not taken with its code");
    a_rsv_taken: assert property (instrValid && instrWord[31:26] == 6'h1f |=> excTake && excCode inside {5'h00, 5'h0a})
        else $error("undefined opcode not taken");
    a_fp_taken: assert property (instrValid && fpExcReq |=> excTake)
        else $error("fp request not taken");
    a_idle_quiet: assert property (!instrValid |=> !excTake)
        else $error("exception without instruction");
    a_vector_common: assert property (excTake |-> excVector inside {64'h0000000080000180, 64'h00000000bfc00380,
                                                                    64'hffffffff80000180, 64'hffffffffbfc00380})
        else $error("exception vector wrong");
    a_int_pending: assert property (excTake && excCode == 5'h00 |-> intPending)
        else $error("interrupt taken while not pending");
    a_code_holds: assert property (!excTake |-> $stable(excCode) && $stable(excVector))
        else $error("code or vector moved without exception");
    a_rd_idle: assert property (!regRd |=> regRdData == 32'h00000000)
        else $error("read data outside read cycle");

    c_int: cover property (excTake && excCode == 5'h00);
    c_cpu: cover property (excTake && excCode == 5'h0b);
    c_fpe: cover property (excTake && excCode == 5'h0f);
endmodule

bind cei_exc_unit cei_exc_unit_properties u_props (
    .clk_sys, .arst_n, .instrValid, .instrWord, .instrPc, .inDelaySlot, .fpExcReq,
    .external_interrupt_request_n, .timerMatch, .compareWrite, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .excTake, .excCode, .excVector, .intPending
);

//--- tb/cei_irq_src.sv
module cei_irq_src (
    input  logic       clk_sys,
    input  logic       arst_n,
    input  logic [5:0] hwCond,
    input  logic       fpCond,
    output logic [5:0] external_interrupt_request_n,
    output logic       fpExcReq
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            external_interrupt_request_n <= 6'h3f;
            fpExcReq <= 1'b0;
        end else begin
            external_interrupt_request_n <= ~hwCond;
            fpExcReq <= fpCond;
        end
    end
endmodule

//--- tb/cei_exc_unit_test.sv
module cei_exc_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, arst_n, instrValid, inDelaySlot, timerMatch, compareWrite, regWr, regRd;
    logic        fpCond, fpExcReq, excTake, intPending;
    logic [31:0] instrWord, regWrData, regRdData;
    logic [63:0] instrPc, excVector;
    logic [2:0]  regAddr;
    logic [4:0]  excCode;
    logic [5:0]  hwCond, external_interrupt_request_n;
    int          failures, checksDone;
    logic [63:0] vecs [4] = '{64'h0000000080000180, 64'hffffffff80000180,
                              64'h00000000bfc00380, 64'hffffffffbfc00380};
    logic [31:0] rsvW [5] = '{32'h7c000000, 32'h00000001, 32'h04040000, 32'h40600000, 32'h41040000};

    cei_exc_unit i_dut (.clk_sys, .arst_n, .instrValid, .instrWord, .instrPc, .inDelaySlot, .fpExcReq,
        .external_interrupt_request_n, .timerMatch, .compareWrite, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .excTake, .excCode, .excVector, .intPending);
    cei_irq_src u_src (.clk_sys, .arst_n, .hwCond, .fpCond, .external_interrupt_request_n, .fpExcReq);
    // core built without floating-point unit
    logic        excTakeNf;
    cei_exc_unit #(.FPU_PRESENT(0)) i_dut_nofp (.clk_sys, .arst_n, .instrValid, .instrWord, .instrPc,
        .inDelaySlot, .fpExcReq, .external_interrupt_request_n, .timerMatch, .compareWrite, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData(), .excTake(excTakeNf), .excCode(), .excVector(),
        .intPending());

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string n);
        checksDone++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        chk(64'(regRdData), 64'(e), n);
    endtask
    task automatic exec(input logic [31:0] w, input logic [63:0] pc, input logic ds, input logic tk,
                        input logic [4:0] c);
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrWord <= w;
        instrPc <= pc;
        inDelaySlot <= ds;
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1;
        chk(64'(excTake), 64'(tk), "take");
        if (tk) chk(64'(excCode), 64'(c), "code");
    endtask
    task automatic complete_run;
        if (failures == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {arst_n, instrValid, inDelaySlot, timerMatch, compareWrite, regWr, regRd, fpCond} = '0;
        {instrWord, regWrData, instrPc, regAddr, hwCond} = '0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(3'h0, 32'h00400002, "status");
        rd(3'h1, 32'h00000000, "cause");
        rd(3'h6, 32'h00000000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            wr(3'h0, (32'(i[1]) << 22) | (32'(i[0]) << 7));
            rd(3'h4, vecs[i][31:0], "vec lo");
            rd(3'h5, vecs[i][63:32], "vec hi");
        end
        wr(3'h0, 32'h00000000);
        exec(32'h03ffffcd, 64'h1000, 1'b1, 1'b1, 5'h09);
        chk(excVector, 64'h0000000080000180, "vector");
        rd(3'h2, 32'h00000ffc, "ret");
        rd(3'h3, 32'h00000000, "ret hi");
        rd(3'h1, 32'h80000024, "cause");
        exec(32'h0000000d, 64'h2000, 1'b0, 1'b1, 5'h09);
        rd(3'h2, 32'h00000ffc, "ret");
        rd(3'h1, 32'h80000024, "cause");
        wr(3'h0, 32'h00000000);
        foreach (rsvW[k]) exec(rsvW[k], 64'h3000, 1'b0, 1'b1, 5'h0a);
        rd(3'h2, 32'h00003000, "ret");
        rd(3'h1, 32'h00000028, "cause");
        wr(3'h0, 32'h00000010);
        exec(32'h60000000, 64'h3000, 1'b0, 1'b1, 5'h0a);
        wr(3'h0, 32'h00000030);
        exec(32'h60000000, 64'h3000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h00000008);
        exec(32'h60000000, 64'h3000, 1'b0, 1'b1, 5'h0a);
        wr(3'h0, 32'h00000048);
        exec(32'h60000000, 64'h3000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h00000000);
        exec(32'h60000000, 64'h3000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h00000010);
        exec(32'h44000000, 64'h4000, 1'b1, 1'b1, 5'h0b);
        rd(3'h2, 32'h00003ffc, "ret");
        rd(3'h1, 32'h9000002c, "cause");
        wr(3'h0, 32'h00000010);
        exec(32'h40000000, 64'h4000, 1'b0, 1'b1, 5'h0b);
        rd(3'h1, 32'h0000002c, "cause");
        wr(3'h0, 32'h10000010);
        exec(32'h40000000, 64'h4000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h00000000);
        exec(32'h40000000, 64'h4000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h20000010);
        exec(32'h44000000, 64'h4000, 1'b0, 1'b0, 5'h00);
        chk(64'(excTakeNf), 64'h1, "take without fpu");
        @(posedge clk_sys);
        fpCond <= 1'b1;
        wr(3'h0, 32'h00000000);
        exec(32'h00000000, 64'h5000, 1'b0, 1'b1, 5'h0f);
        wr(3'h0, 32'h00000000);
        exec(32'h00000000, 64'h5000, 1'b0, 1'b1, 5'h0f);
        @(posedge clk_sys);
        fpCond <= 1'b0;
        wr(3'h0, 32'h00000000);
        exec(32'h00000000, 64'h5000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h0040ff01);
        wr(3'h1, 32'h00000100);
        rd(3'h1, 32'h0000013c, "cause");
        chk(64'(intPending), 64'h1, "pend");
        exec(32'h00000000, 64'h6000, 1'b0, 1'b1, 5'h00);
        chk(excVector, 64'h00000000bfc00380, "vector");
        wr(3'h1, 32'h00000000);
        rd(3'h1, 32'h00000000, "cause");
        wr(3'h0, 32'h0040fe01);
        wr(3'h1, 32'h00000100);
        exec(32'h00000000, 64'h6000, 1'b0, 1'b0, 5'h00);
        wr(3'h0, 32'h0040ff00);
        exec(32'h00000000, 64'h6000, 1'b0, 1'b0, 5'h00);
        wr(3'h1, 32'h00000000);
        wr(3'h0, 32'h0040ff01);
        @(posedge clk_sys);
        hwCond <= 6'h01;
        repeat (5) @(posedge clk_sys);
        #1;
        chk(64'(intPending), 64'h1, "pend");
        rd(3'h1, 32'h00000400, "cause");
        exec(32'h00000000, 64'h7000, 1'b0, 1'b1, 5'h00);
        wr(3'h0, 32'h0040ff01);
        exec(32'h00000000, 64'h7000, 1'b0, 1'b1, 5'h00);
        @(posedge clk_sys);
        hwCond <= 6'h00;
        repeat (3) @(posedge clk_sys);
        wr(3'h0, 32'h0040ff01);
        exec(32'h00000000, 64'h7000, 1'b0, 1'b0, 5'h00);
        @(posedge clk_sys);
        timerMatch <= 1'b1;
        @(posedge clk_sys);
        timerMatch <= 1'b0;
        rd(3'h1, 32'h00008000, "cause");
        @(posedge clk_sys);
        compareWrite <= 1'b1;
        @(posedge clk_sys);
        compareWrite <= 1'b0;
        rd(3'h1, 32'h00000000, "cause");
        @(posedge clk_sys);
        timerMatch <= 1'b1;
        compareWrite <= 1'b1;
        @(posedge clk_sys);
        timerMatch <= 1'b0;
        compareWrite <= 1'b0;
        rd(3'h1, 32'h00008000, "cause");
        @(posedge clk_sys);
        timerMatch <= 1'b1;
        @(posedge clk_sys);
        timerMatch <= 1'b0;
        wr(3'h1, 32'h00000000);
        rd(3'h1, 32'h00000000, "cause");
        complete_run();
    end
endmodule
